/* File: vga_640x480_timing_generator.sv */
/*
 * 640x480 raster timing generator: pixel clock divider, line and frame
 * counters, sync generation, read-ahead of pixel colours from a refresh
 * memory through a FIFO, and registered colour and sync outputs.
 * Assumes the memory answers fetch requests in order, one word each, on
 * the same clock, and is quiet when a new frame restarts the fetch.
 */
`timescale 1ns/1ps
`include "vga_timing_consts.svh"
module vga_640x480_timing_generator #(
   parameter int PIX_DIV = `VGA_PIX_DIV,
   parameter int FIFO_DEPTH = `VGA_FIFO_DEPTH
)(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   output logic fetch_valid_o,
   input wire logic fetch_ready_i,
   output logic [`VGA_ADDR_W-1:0] fetch_addr_o,
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire logic [`VGA_PIX_W-1:0] pix_data_i,
   output logic [2:0] red_o,
   output logic [2:0] green_o,
   output logic [1:0] blue_o,
   output logic hsync_n_o,
   output logic vsync_n_o,
   output logic underrun_o
);
   localparam int DIV_W = $clog2(PIX_DIV + 1);
   localparam int CRD_W = $clog2(FIFO_DEPTH + 1);
   localparam int CW = `VGA_CNT_W;
   localparam int AW = `VGA_ADDR_W;

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_next;
   logic [CW-1:0] h_reg;
   logic [CW-1:0] h_next;
   logic [CW-1:0] v_reg;
   logic [CW-1:0] v_next;
   logic [CW-1:0] fcol_reg;
   logic [CW-1:0] fcol_next;
   logic [CW-1:0] frow_reg;
   logic [CW-1:0] frow_next;
   logic [CRD_W-1:0] credit_reg;
   logic [CRD_W-1:0] credit_next;
   logic [AW-1:0] skip_reg;
   logic [AW-1:0] skip_next;
   logic [AW-1:0] addr_reg;
   logic [`VGA_PIX_W-1:0] colour_reg;
   logic [`VGA_PIX_W-1:0] colour_next;
   logic fetch_valid_reg;
   logic fetch_valid_next;
   logic hsync_n_reg;
   logic hsync_n_next;
   logic vsync_n_reg;
   logic vsync_n_next;
   logic underrun_reg;
   logic live_reg;
   vga_timing_pkg::fetch_state_t state_reg;
   vga_timing_pkg::fetch_state_t state_next;
   vga_timing_pkg::region_t h_region;
   vga_timing_pkg::region_t v_region;

   wire pix_tick;
   wire h_last;
   wire v_last;
   wire line_end;
   wire frame_restart;
   wire disp_vis;
   wire fetch_hs;
   wire fcol_last;
   wire fetch_last;
   wire fetch_want;
   wire fifo_valid;
   wire [`VGA_PIX_W-1:0] fifo_data;
   wire skip_zero;
   wire show;
   wire miss;
   wire discard;
   wire pop;

   // ****************************************************************
   // pixel clock
   // ****************************************************************
   // pixel rate divider
   // the 25 MHz pixel period is a fixed count of system clocks, so the
   // divider has no phase drift against the line and frame counts
   assign pix_tick = (div_reg == DIV_W'(PIX_DIV - 1));
   assign div_next = pix_tick ? '0 : DIV_W'(div_reg + 1'b1);

   // ****************************************************************
   // raster counters
   // ****************************************************************
   // line wrap
   assign h_last = (h_reg == `VGA_H_LAST);
   assign h_next = !pix_tick ? h_reg :
      h_last ? '0 : CW'(h_reg + 1'b1);

   // row step at line end
   // stepping at the end of the line keeps the row constant across all
   // visible columns, which lets visibility be a plain AND of the two regions
   assign line_end = pix_tick && h_last;

   assign v_last = (v_reg == `VGA_V_LAST);
   assign v_next = !line_end ? v_reg :
      v_last ? '0 : CW'(v_reg + 1'b1);

   assign h_region = vga_timing_pkg::region_of(h_reg, `VGA_H_VISIBLE,
      `VGA_H_FP_END, `VGA_H_SYNC_END);

   assign v_region = vga_timing_pkg::region_of(v_reg, `VGA_V_VISIBLE,
      `VGA_V_FP_END, `VGA_V_SYNC_END);

   assign disp_vis = (h_region == vga_timing_pkg::REGION_VISIBLE) &&
      (v_region == vga_timing_pkg::REGION_VISIBLE);

   // fetching restarts as vertical sync begins, which leaves the whole
   // sync and back porch for the FIFO to fill before row 0
   assign frame_restart = line_end &&
      (v_reg == (`VGA_V_FP_END - 10'h001));

   // ****************************************************************
   // fetch request generator
   // ****************************************************************
   // address from column and row
   assign fetch_hs = fetch_valid_reg && fetch_ready_i;
   assign fcol_last = (fcol_reg == (`VGA_H_VISIBLE - 10'h001));
   assign fetch_last = fcol_last &&
      (frow_reg == (`VGA_V_VISIBLE - 10'h001));
   assign fcol_next = frame_restart ? '0 :
      !fetch_hs ? fcol_reg :
      fcol_last ? '0 : CW'(fcol_reg + 1'b1);
   assign frow_next = frame_restart ? '0 :
      (fetch_hs && fcol_last) ? CW'(frow_reg + 1'b1) : frow_reg;

   // read ahead by credit
   // credits count words asked for and not yet consumed, so the FIFO
   // can never be asked to hold more than its depth
   assign credit_next = frame_restart ? '0 :
      CRD_W'(credit_reg + CRD_W'(fetch_hs) - CRD_W'(pop));
   assign fetch_want = (state_next == vga_timing_pkg::FETCH_RUN) &&
      (credit_next < CRD_W'(FIFO_DEPTH));
   assign fetch_valid_next = frame_restart ? 1'b0 :
      (!fetch_valid_reg || fetch_ready_i) ? fetch_want : fetch_valid_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         vga_timing_pkg::FETCH_IDLE:
         begin
            if (frame_restart)
               state_next = vga_timing_pkg::FETCH_RUN;
         end
         vga_timing_pkg::FETCH_RUN:
         begin
            if (frame_restart)
               state_next = vga_timing_pkg::FETCH_RUN;
            else if (fetch_hs && fetch_last)
               state_next = vga_timing_pkg::FETCH_IDLE;
         end
         default:
            state_next = vga_timing_pkg::FETCH_IDLE;
      endcase
   end

   // ****************************************************************
   // pixel buffer
   // ****************************************************************
   pixel_fifo #(
      .WIDTH(`VGA_PIX_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .flush_i(frame_restart),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .in_data_i(pix_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data)
   );

   // ****************************************************************
   // pixel consumer
   // ****************************************************************
   // one word per pixel period
   // a pixel missed for lack of data is owed: the late word is dropped
   // so the rest of the frame stays on its own positions
   assign skip_zero = (skip_reg == '0);
   assign show = pix_tick && disp_vis && live_reg && skip_zero &&
      fifo_valid;
   assign miss = pix_tick && disp_vis && live_reg &&
      !(skip_zero && fifo_valid);
   assign discard = fifo_valid && !skip_zero;
   assign pop = show || discard;
   assign skip_next = frame_restart ? '0 :
      AW'(skip_reg + AW'(miss) - AW'(discard));

   assign colour_next = !pix_tick ? colour_reg :
      show ? fifo_data : '0;

   assign hsync_n_next = !pix_tick ? hsync_n_reg :
      (h_region != vga_timing_pkg::REGION_SYNC);
   assign vsync_n_next = !pix_tick ? vsync_n_reg :
      (v_region != vga_timing_pkg::REGION_SYNC);

   // ****************************************************************
   // registers
   // ****************************************************************
   // reset to first pixel
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         div_reg <= '0;
         h_reg <= '0;
         v_reg <= '0;
      end
      else
      begin
         div_reg <= div_next;
         h_reg <= h_next;
         v_reg <= v_next;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         state_reg <= vga_timing_pkg::FETCH_IDLE;
         fcol_reg <= '0;
         frow_reg <= '0;
         credit_reg <= '0;
         fetch_valid_reg <= 1'b0;
         addr_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         fcol_reg <= fcol_next;
         frow_reg <= frow_next;
         credit_reg <= credit_next;
         fetch_valid_reg <= fetch_valid_next;
         addr_reg <= {frow_next[`VGA_ROW_W-1:0], fcol_next};
      end
   end

   // the first frame after reset is dark: nothing was fetched for it
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         live_reg <= 1'b0;
         skip_reg <= '0;
         underrun_reg <= 1'b0;
      end
      else
      begin
         live_reg <= live_reg || frame_restart;
         skip_reg <= skip_next;
         underrun_reg <= miss;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         colour_reg <= '0;
         hsync_n_reg <= `VGA_SYNC_IDLE;
         vsync_n_reg <= `VGA_SYNC_IDLE;
      end
      else
      begin
         colour_reg <= colour_next;
         hsync_n_reg <= hsync_n_next;
         vsync_n_reg <= vsync_n_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign red_o = colour_reg[7:5];
   assign green_o = colour_reg[4:2];
   assign blue_o = colour_reg[1:0];
   assign hsync_n_o = hsync_n_reg;
   assign vsync_n_o = vsync_n_reg;
   assign underrun_o = underrun_reg;
   assign fetch_valid_o = fetch_valid_reg;
   assign fetch_addr_o = addr_reg;
endmodule

/* File: vga_timing_consts.svh */
/*
 * Constants of the 640x480 raster timing generator: pixel clock divider,
 * line and frame segment lengths, colour and address widths, FIFO depth.
 * Assumes it is included by bare name after the package that holds types.
 */
`ifndef VGA_TIMING_CONSTS_SVH
`define VGA_TIMING_CONSTS_SVH

// ****************************************************************
// clocking
// ****************************************************************
`define VGA_SYS_CLK_MHZ 250
`define VGA_PIX_CLK_MHZ 25
`define VGA_PIX_PERIOD_NS 40
`define VGA_SYS_PERIOD_NS 4
`define VGA_PIX_DIV (`VGA_PIX_PERIOD_NS / `VGA_SYS_PERIOD_NS)
`define VGA_LINE_TIME_NS 32000

// ****************************************************************
// horizontal timing, in pixel clocks
// ****************************************************************
`define VGA_H_VISIBLE 10'h280
`define VGA_H_FRONT 10'h010
`define VGA_H_SYNC 10'h060
`define VGA_H_BACK 10'h030
`define VGA_H_FP_END (`VGA_H_VISIBLE + `VGA_H_FRONT)
`define VGA_H_SYNC_END (`VGA_H_FP_END + `VGA_H_SYNC)
`define VGA_H_LAST (`VGA_H_SYNC_END + `VGA_H_BACK - 10'h001)

// ****************************************************************
// vertical timing, in lines
// ****************************************************************
`define VGA_V_VISIBLE 10'h1E0
`define VGA_V_FRONT 10'h00A
`define VGA_V_SYNC 10'h002
`define VGA_V_BACK 10'h01D
`define VGA_V_FP_END (`VGA_V_VISIBLE + `VGA_V_FRONT)
`define VGA_V_SYNC_END (`VGA_V_FP_END + `VGA_V_SYNC)
`define VGA_V_LAST (`VGA_V_SYNC_END + `VGA_V_BACK - 10'h001)

// ****************************************************************
// widths and buffering
// ****************************************************************
`define VGA_CNT_W 10
`define VGA_ROW_W 9
`define VGA_ADDR_W 19
`define VGA_PIX_W 8
`define VGA_FIFO_DEPTH 16
`define VGA_SYNC_IDLE 1'b1

`endif

/* File: vga_timing_pkg.sv */
/*
 * Types of the raster timing generator: segment and fetch state enums
 * and the segment decode function. Assumes the constants header is
 * included before any user of this package.
 */
package vga_timing_pkg;

   // ****************************************************************
   // enumerations
   // ****************************************************************
   typedef enum logic [1:0] {
      REGION_VISIBLE,
      REGION_FRONT,
      REGION_SYNC,
      REGION_BACK
   } region_t;

   typedef enum logic {
      FETCH_IDLE,
      FETCH_RUN
   } fetch_state_t;

   // ****************************************************************
   // segment decode
   // ****************************************************************
   function automatic region_t region_of(
      input logic [9:0] cnt,
      input logic [9:0] vis_end,
      input logic [9:0] fp_end,
      input logic [9:0] sync_end
   );
      region_t r;
      if (cnt < vis_end)
         r = REGION_VISIBLE;
      else if (cnt < fp_end)
         r = REGION_FRONT;
      else if (cnt < sync_end)
         r = REGION_SYNC;
      else
         r = REGION_BACK;
      return r;
   endfunction

endpackage

/* File: pixel_fifo.sv */
/*
 * Small flip-flop FIFO with valid and ready on both sides and a flush.
 * Assumes one clock and a synchronous active-high reset; flush wins over
 * a push in the same cycle.
 */
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
)(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic push;
   logic pop;

   assign push = in_valid_i && in_ready_o && !flush_i;
   assign pop = out_valid_o && out_ready_i && !flush_i;
   assign count_next = flush_i ? '0 :
      CNT_W'(count_reg + CNT_W'(push) - CNT_W'(pop));
   assign out_data_o = mem_reg[rd_ptr_reg];

   function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
      return (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
   endfunction

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data_i;
   end

   // ready and valid are registered so that neither side sees a loop
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wr_ptr_reg <= flush_i ? '0 : push ? ptr_inc(wr_ptr_reg) : wr_ptr_reg;
         rd_ptr_reg <= flush_i ? '0 : pop ? ptr_inc(rd_ptr_reg) : rd_ptr_reg;
         count_reg <= count_next;
         in_ready_o <= (count_next != CNT_W'(DEPTH));
         out_valid_o <= (count_next != '0);
      end
   end
endmodule

/* File: vga_timing_checker_assertions.sv */
/*
 * Port checker of the raster generator: hsync width, line period,
 * blanking, reset state, fetch address hold and colour pacing.
 * Assumes one clock domain and PIX_DIV of at least 2.
 */
`timescale 1ns/1ps
`include "vga_timing_consts.svh"
module vga_timing_checker #(
   parameter int PIX_DIV = 10,
   parameter int FIFO_DEPTH = 16
)(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic fetch_valid_o,
   input wire logic fetch_ready_i,
   input wire logic [`VGA_ADDR_W-1:0] fetch_addr_o,
   input wire logic [2:0] red_o,
   input wire logic [2:0] green_o,
   input wire logic [1:0] blue_o,
   input wire logic hsync_n_o,
   input wire logic vsync_n_o
);
   localparam int HS_LOW = 96 * PIX_DIV;
   localparam int LINE = 800 * PIX_DIV;
   wire [7:0] colour = {red_o, green_o, blue_o};
   int hs_low;
   int hs_age;
   logic hs_prev;
   logic hs_seen;

   // ****************
   // helper counters
   // ****************
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         hs_low <= 0;
         hs_age <= 0;
         hs_prev <= 1'h1;
         hs_seen <= 1'h0;
      end
      else
      begin
         hs_low <= hsync_n_o ? 0 : hs_low + 1;
         hs_age <= (hs_prev && !hsync_n_o) ? 1 : hs_age + 1;
         hs_seen <= hs_seen | (hs_prev & ~hsync_n_o);
         hs_prev <= hsync_n_o;
      end
   end

   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   property p_hs_width;
      $rose(hsync_n_o) |-> hs_low == HS_LOW;
   endproperty
   a_hs_width: assert property (p_hs_width)
      else $error("hsync pulse width wrong");
   property p_line_len;
      $fell(hsync_n_o) && hs_seen |-> hs_age == LINE;
   endproperty
   a_line_len: assert property (p_line_len)
      else $error("line period wrong");
   property p_blank_hs;
      !hsync_n_o |-> colour == 8'h00;
   endproperty
   a_blank_hs: assert property (p_blank_hs)
      else $error("colour during hsync");
   property p_blank_vs;
      !vsync_n_o |-> colour == 8'h00;
   endproperty
   a_blank_vs: assert property (p_blank_vs)
      else $error("colour during vsync");
   property p_reset_idle;
      $fell(reset_i) |-> hsync_n_o && vsync_n_o && colour == 8'h00
         && !fetch_valid_o;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("outputs not idle after reset");
   property p_addr_hold;
      fetch_valid_o && !fetch_ready_i |=> !fetch_valid_o
         || $stable(fetch_addr_o);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("fetch address moved while waiting");
   property p_colour_hold;
      $changed(colour) |=> $stable(colour);
   endproperty
   a_colour_hold: assert property (p_colour_hold)
      else $error("colour not held for its pixel");
   property p_vs_align;
      $changed(vsync_n_o) |-> hsync_n_o && colour == 8'h00;
   endproperty
   a_vs_align: assert property (p_vs_align)
      else $error("vsync edge off line start");
   c_line: cover property ($fell(hsync_n_o));
   c_fetch: cover property (fetch_valid_o && fetch_ready_i);
   c_frame: cover property ($fell(vsync_n_o));
endmodule

bind vga_640x480_timing_generator vga_timing_checker #(
   .PIX_DIV(PIX_DIV),
   .FIFO_DEPTH(FIFO_DEPTH)
) u_checker (
   .clk_sys_i(clk_sys_i),
   .reset_i(reset_i),
   .fetch_valid_o(fetch_valid_o),
   .fetch_ready_i(fetch_ready_i),
   .fetch_addr_o(fetch_addr_o),
   .red_o(red_o),
   .green_o(green_o),
   .blue_o(blue_o),
   .hsync_n_o(hsync_n_o),
   .vsync_n_o(vsync_n_o)
);

/* File: vga_monitor_model.sv */
/*
 * Behavioural display: measures hsync pulses and line period in system clocks and counts
 * colour seen while either sync is active.
 * Assumes it shares the generator's clock and reset.
 */
`timescale 1ns/1ps
module vga_monitor_model (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic hsync_n_i,
   input wire logic vsync_n_i,
   input wire logic [7:0] colour_i,
   output int lines_o,
   output int hs_width_o,
   output int line_len_o,
   output int blank_errs_o
);
   int low_run;
   int age;
   logic prev;
   // a real set locks to the edges; counting clocks is enough here
   always @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         lines_o <= 0;
         hs_width_o <= 0;
         line_len_o <= 0;
         blank_errs_o <= 0;
         low_run <= 0;
         age <= 0;
         prev <= 1'h1;
      end
      else
      begin
         age <= age + 1;
         if (prev && !hsync_n_i)
         begin
            lines_o <= lines_o + 1;
            line_len_o <= age;
            age <= 1;
         end
         if (!prev && hsync_n_i)
            hs_width_o <= low_run;
         low_run <= hsync_n_i ? 0 : low_run + 1;
         if ((!hsync_n_i || !vsync_n_i) && colour_i != 8'h00)
            blank_errs_o <= blank_errs_o + 1;
         prev <= hsync_n_i;
      end
   end
endmodule

/* File: vga_640x480_timing_generator_tb_top.sv */
/*
 * Testbench of the raster generator; the bench plays refresh memory and
 * a monitor model watches the pins.
 * Assumes PIX_DIV of 2, so one line lasts 1600 clocks.
 */
`timescale 1ns/1ps
module vga_640x480_timing_generator_tb_top;
   logic clk_sys_i = 1'h0;
   logic reset_i = 1'h1;
   logic pix_valid_i = 1'h0;
   logic [7:0] pix_data_i = 8'hFF;
   logic fetch_ready_i = 1'h1;
   wire fetch_valid_o, pix_ready_o, hsync_n_o, vsync_n_o, underrun_o;
   wire [18:0] fetch_addr_o;
   wire [2:0] red_o, green_o;
   wire [1:0] blue_o;
   int lines, hs_width, line_len, blank_errs;
   int bad_count = 0;
   int n_tests = 0;

   vga_640x480_timing_generator #(.PIX_DIV(2), .FIFO_DEPTH(16)) dut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .fetch_valid_o(fetch_valid_o), .fetch_ready_i(fetch_ready_i),
      .fetch_addr_o(fetch_addr_o), .pix_valid_i(pix_valid_i),
      .pix_ready_o(pix_ready_o), .pix_data_i(pix_data_i),
      .red_o(red_o), .green_o(green_o), .blue_o(blue_o),
      .hsync_n_o(hsync_n_o), .vsync_n_o(vsync_n_o),
      .underrun_o(underrun_o));
   vga_monitor_model mon (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsync_n_i(hsync_n_o),
      .vsync_n_i(vsync_n_o), .colour_i({red_o, green_o, blue_o}),
      .lines_o(lines), .hs_width_o(hs_width), .line_len_o(line_len),
      .blank_errs_o(blank_errs));

   initial
   begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // ****************
   // shared tasks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t seen %0h want %0h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // a wait that ran out ends the run
   task automatic need(input logic ok);
      if (!ok)
      begin
         bad_count++;
         $display("BAD t=%0t wait ran out", $time);
         tally_and_finish();
      end
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic t_reset(input int pre);
      step(pre);
      reset_i = 1'h1;
      step(8);
      check({red_o, green_o, blue_o, hsync_n_o, vsync_n_o, fetch_valid_o,
         underrun_o, pix_ready_o}, 13'h0019);
      check(fetch_addr_o, 32'h0000_0000);
      reset_i = 1'h0;
      step(1);
      check({red_o, green_o, blue_o, hsync_n_o, vsync_n_o}, 10'h003);
      step(1312);
      check(hsync_n_o, 1'h1);
      step(1);
      check(hsync_n_o, 1'h0);
      $display("test reset release done");
   endtask

   task automatic t_line;
      int i;
      for (i = 0; i < 6000 && lines < 3; i++)
         step(1);
      need(lines >= 3);
      check(hs_width, 192);
      check(line_len, 1600);
      check(blank_errs, 0);
      $display("test line timing done");
   endtask

   task automatic t_fifo;
      int i;
      int got;
      got = 0;
      for (i = 0; i < 2000 && hsync_n_o; i++)
         step(1);
      need(!hsync_n_o);
      pix_valid_i = 1'h1;
      for (i = 0; i < 40 && got < 16; i++)
      begin
         if (pix_ready_o === 1'h1)
            got++;
         step(1);
      end
      check(got, 16);
      check(pix_ready_o, 1'h0);
      step(3);
      check(pix_ready_o, 1'h0);
      pix_valid_i = 1'h0;
      $display("test buffer fill done");
   endtask

   // 40 lines of the first frame, from the third line on, stay black and no fetch starts in them
   task automatic t_black;
      int i;
      int odd;
      odd = 0;
      // memory stalls too: a request must still not appear
      fetch_ready_i = 1'h0;
      for (i = 0; i < 40 * 1600; i++)
      begin
         step(1);
         if ({red_o, green_o, blue_o, fetch_valid_o, underrun_o,
            vsync_n_o} !== 11'h001)
            odd++;
      end
      fetch_ready_i = 1'h1;
      check(odd, 0);
      check(blank_errs, 0);
      $display("test black frame done");
   endtask

   initial
   begin
      t_reset(0);
      t_line();
      t_fifo();
      t_black();
      t_reset(700);
      tally_and_finish();
   end
endmodule
